// ### rtl/seep_pkg.sv
// Constants and types shared by both ends of the protected two-wire memory link.
// Assumes both ends run from a 250 MHz system clock.
package seep_pkg;
  // System clock period
  localparam int CLK_NS = 4;
  // Array shape: 256 words of 8 bits, 16-byte pages
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int DEPTH = 256;
  localparam int PAGE_AW = 4;
  // Address bit that separates lower and upper half
  localparam int HALF_BIT = 7;
  // Control byte type codes and direction bit
  localparam logic [3:0] CODE_ARRAY = 4'hA;
  localparam logic [3:0] CODE_PROT = 4'h6;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  // Clock counts inside one word: eight data bits, then the acknowledge
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] END_BIT = 4'h9;
  // Byte shifted out by a flag query
  localparam logic [7:0] UNDEF_BYTE = 8'hFF;
  // Bus timing
  localparam int T_LOW_NS = 1200;
  localparam int T_HIGH_NS = 600;
  localparam int T_WR_MS = 5;
  localparam int LOW_CYC = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (T_WR_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  // Controller operations
  typedef enum logic [2:0] {
    OP_WRITE,
    OP_READ_CUR,
    OP_READ_RAND,
    OP_PROT_SET,
    OP_PROT_QUERY
  } seep_op_t;
endpackage : seep_pkg

// ### rtl/seep_link_if.sv
// Two-wire link between the controller end and the memory end.
// Assumes a pull-up: data is the wired-AND of both open-drain drivers.
interface seep_link_if;
  logic scl;
  logic sda;
  logic hostSdaOut;
  logic hostSdaOeB;
  logic devSdaOut;
  logic devSdaOeB;
  // Open-drain data wire resolved from both enables
  assign sda = (hostSdaOeB | hostSdaOut) & (devSdaOeB | devSdaOut);
  modport device (input scl, input sda, output devSdaOut, output devSdaOeB);
  modport host (output scl, input sda, output hostSdaOut, output hostSdaOeB);
endinterface : seep_link_if

// ### rtl/seep_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs are levels; no logic reads the first stage.
module seep_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Levels in and out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } seep_sync_t;
  seep_sync_t state_q;
  seep_sync_t state_d;

  // Shift the pins through two stages
  always_comb begin
    state_d.s1 = din;
    state_d.s2 = state_q.s1;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign dout = state_q.s2;
endmodule : seep_sync

// ### rtl/seep_device.sv
// Memory end of the link: 256-byte array with one-way software protect flag,
// hardware protect pin, flag query, and current, random and sequential reads.
// Assumes the controller drives the serial clock; every pin is synchronised here.
// Operation
// RQ1: Flag set blocks writes to lower half
// RQ2: Protect pin high blocks every array write
// RQ3: Code 0110 write sets the flag
// RQ4: Flag set: no acknowledge for 0110 code
// RQ5: Flag is one-way, never cleared
// RQ6: Controller waits write cycle after setting flag
// RQ7: Pin high: 0110 acknowledged, flag unchanged
// RQ8: Pin low: protection follows flag only
// RQ9: Flag set: 1010 write acknowledged, upper only
// RQ10: 0110 read, flag clear: acknowledge, undefined byte
// RQ11: Query flag: acknowledge means clear
// RQ12: Reads start like writes, direction bit one
// RQ13: Counter holds last address plus one
// RQ14: Read counter wraps top to bottom
// RQ15: Read control acknowledged: shift out current byte
// RQ16: Random read: dummy write, restart, read
// RQ17: Controller acknowledge: advance, send next byte
// RQ18: Controller ends read with no-ack, stop
// RQ19: Control byte: code, three selects, direction
// RQ20: Respond only on matching select bits
// RQ21: Eight-bit words, zero acknowledge ninth clock
module seep_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Two-wire link
  seep_link_if.device link,
  // Hard-wired select straps and protect pin
  input wire logic chipSelectBit2,
  input wire logic chipSelectBit1,
  input wire logic chipSelectBit0,
  input wire logic writeProtect,
  // Status
  output logic protectFlag,
  output logic [seep_pkg::AW-1:0] wordAddr
);
  import seep_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////////////////

  typedef enum logic [2:0] {
    DS_IDLE,
    DS_CTRL,
    DS_ADDR,
    DS_DATA,
    DS_TX
  } seep_dst_t;

  typedef struct packed {
    seep_dst_t st;
    logic [3:0] bitCnt;
    logic [DW-1:0] rxSh;
    logic [DW-1:0] txSh;
    logic [AW-1:0] addr;
    logic isProt;
    logic isRead;
    logic sdaDrv;
    logic mAck;
    logic protPend;
    logic protFlag;
    logic sclPrev;
    logic sdaPrev;
    logic [DEPTH-1:0][DW-1:0] mem;
  } seep_dev_t;

  seep_dev_t state_q;
  seep_dev_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ////////////////////////////////////////////////////////////////////////////

  logic [5:0] pinSync;
  logic sclS;
  logic sdaS;
  logic wpS;
  logic [2:0] csS;

  seep_sync #(
    .W(6)
  ) u_pins (
    .clk(clk),
    .rst_b(rst_b),
    .din({link.scl, link.sda, writeProtect,
          chipSelectBit2, chipSelectBit1, chipSelectBit0}),
    .dout(pinSync)
  );

  // Name the synchronised levels
  assign sclS = pinSync[5];
  assign sdaS = pinSync[4];
  assign wpS = pinSync[3];
  assign csS = pinSync[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus events and decode
  ////////////////////////////////////////////////////////////////////////////

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic selOk;
  logic codeArray;
  logic codeProt;
  logic respond;
  logic wrAllowed;
  logic [DW-1:0] txByte;
  logic [AW-1:0] pageNext;
  logic [AW-1:0] seqNext;

  // Clock edges, and data moving while the clock is high
  assign sclRise = sclS & ~state_q.sclPrev;
  assign sclFall = ~sclS & state_q.sclPrev;
  assign startSeen = sclS & state_q.sclPrev & state_q.sdaPrev & ~sdaS;
  assign stopSeen = sclS & state_q.sclPrev & ~state_q.sdaPrev & sdaS;

  // Control byte: type code, select bits, direction
  assign selOk = (state_q.rxSh[3:1] == csS); // [RQ19] [RQ20]
  assign codeArray = (state_q.rxSh[7:4] == CODE_ARRAY); // [RQ19]
  assign codeProt = (state_q.rxSh[7:4] == CODE_PROT); // [RQ19]
  // A set flag silences the protect code for good
  assign respond = selOk & (codeArray | (codeProt & ~state_q.protFlag)); // [RQ4] [RQ20]

  // Pin high guards all; otherwise only the flag guards the lower half
  assign wrAllowed = ~wpS & (~state_q.protFlag | state_q.addr[HALF_BIT]); // [RQ1] [RQ2] [RQ8] [RQ9]

  // Byte to shift out: array word, or filler on a flag query
  assign txByte = state_q.isProt ? UNDEF_BYTE : state_q.mem[state_q.addr]; // [RQ10] [RQ15]

  // Writes roll inside the page, reads roll over the whole array
  assign pageNext = {state_q.addr[AW-1:PAGE_AW],
                     state_q.addr[PAGE_AW-1:0] + 1'b1};
  assign seqNext = state_q.addr + 1'b1; // [RQ14]

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  ////////////////////////////////////////////////////////////////////////////

  // Protocol engine: receive, acknowledge, transmit
  always_comb begin
    state_d = state_q;
    state_d.sclPrev = sclS;
    state_d.sdaPrev = sdaS;
    if (startSeen) begin
      // Start or repeated start: expect a control byte
      state_d.st = DS_CTRL;
      state_d.bitCnt = '0;
      state_d.sdaDrv = 1'b0;
    end else if (stopSeen) begin
      // A pending flag set takes effect only with the pin low
      if (state_q.protPend && !wpS) begin
        state_d.protFlag = 1'b1; // [RQ3] [RQ7]
      end
      state_d.protPend = 1'b0;
      state_d.st = DS_IDLE;
      state_d.sdaDrv = 1'b0;
    end else if (state_q.st != DS_IDLE) begin
      if (sclRise) begin
        state_d.bitCnt = state_q.bitCnt + 4'h1;
        // Eight data bits, most significant first
        if (state_q.bitCnt < ACK_BIT) begin
          state_d.rxSh = {state_q.rxSh[DW-2:0], sdaS}; // [RQ21]
        end
        // Ninth clock: controller acknowledge after a sent byte
        if (state_q.bitCnt == ACK_BIT) begin
          state_d.mAck = ~sdaS; // [RQ17]
        end
      end else if (sclFall) begin
        if (state_q.bitCnt == ACK_BIT) begin
          // Word complete: decide the acknowledge
          state_d.sdaDrv = 1'b0;
          unique case (state_q.st)
            DS_IDLE: ;
            DS_CTRL: begin
              if (respond) begin
                state_d.sdaDrv = 1'b1; // [RQ21] [RQ7] [RQ10]
                state_d.isProt = codeProt;
                state_d.isRead = state_q.rxSh[0]; // [RQ12]
              end else begin
                state_d.st = DS_IDLE; // [RQ4] [RQ20]
              end
            end
            DS_ADDR: begin
              state_d.sdaDrv = 1'b1;
              // Address byte of a flag set carries no meaning
              if (!state_q.isProt) begin
                state_d.addr = state_q.rxSh; // [RQ16]
              end
            end
            DS_DATA: begin
              state_d.sdaDrv = 1'b1; // [RQ9]
              if (!state_q.isProt) begin
                if (wrAllowed) begin
                  state_d.mem[state_q.addr] = state_q.rxSh; // [RQ1] [RQ2]
                end
                state_d.addr = pageNext; // [RQ13]
              end
            end
            DS_TX: state_d.sdaDrv = 1'b0;
          endcase
        end else if (state_q.bitCnt == END_BIT) begin
          // Ninth clock over: release and move on
          state_d.bitCnt = '0;
          state_d.sdaDrv = 1'b0;
          unique case (state_q.st)
            DS_IDLE: ;
            DS_CTRL: begin
              if (state_q.isRead) begin
                state_d.st = DS_TX; // [RQ15]
                state_d.txSh = txByte;
                state_d.sdaDrv = ~txByte[DW-1];
                if (!state_q.isProt) begin
                  state_d.addr = seqNext; // [RQ13] [RQ14]
                end
              end else begin
                state_d.st = DS_ADDR;
                state_d.protPend = state_q.isProt; // [RQ3]
              end
            end
            DS_ADDR: state_d.st = DS_DATA;
            DS_DATA: state_d.st = DS_DATA;
            DS_TX: begin
              if (state_q.mAck) begin
                // Acknowledged: next byte, counter advances
                state_d.txSh = txByte; // [RQ17]
                state_d.sdaDrv = ~txByte[DW-1];
                if (!state_q.isProt) begin
                  state_d.addr = seqNext; // [RQ14] [RQ17]
                end
              end else begin
                state_d.st = DS_IDLE; // [RQ18]
              end
            end
          endcase
        end else if (state_q.st == DS_TX) begin
          // Next data bit while the clock is low
          state_d.txSh = {state_q.txSh[DW-2:0], 1'b0};
          state_d.sdaDrv = ~state_q.txSh[DW-2];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and outputs
  ////////////////////////////////////////////////////////////////////////////

  // Reset stands for a fresh part: blank array, flag clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
      state_q.sclPrev <= 1'b1;
      state_q.sdaPrev <= 1'b1;
    end else begin
      state_q <= state_d; // [RQ5]
    end
  end

  // Open-drain data: only ever pulled low
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOeB = ~state_q.sdaDrv;
  assign protectFlag = state_q.protFlag;
  assign wordAddr = state_q.addr;
endmodule : seep_device

// ### rtl/seep_host.sv
// Controller end of the link: makes the serial clock and runs one operation
// per request. Assumes one memory end on the link; data pin is synchronised.
module seep_host #(
  parameter int LOW_CYC_P = seep_pkg::LOW_CYC,
  parameter int HIGH_CYC_P = seep_pkg::HIGH_CYC,
  parameter int WR_WAIT_CYC = seep_pkg::WR_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Two-wire link
  seep_link_if.host link,
  // Request
  input wire logic reqValid,
  output logic reqReady,
  input wire seep_pkg::seep_op_t reqOp,
  input wire logic [2:0] reqCs,
  input wire logic [seep_pkg::AW-1:0] reqAddr,
  input wire logic [seep_pkg::DW-1:0] reqData,
  input wire logic [seep_pkg::DW-1:0] reqLen,
  // Answer
  output logic rspValid,
  output logic [seep_pkg::DW-1:0] rspData,
  output logic rspNack,
  output logic rspLast
);
  import seep_pkg::*;

  localparam int TW = $clog2(WR_WAIT_CYC + LOW_CYC_P + HIGH_CYC_P);
  localparam logic [TW-1:0] LOW_T = TW'(LOW_CYC_P - 1);
  localparam logic [TW-1:0] HIGH_T = TW'(HIGH_CYC_P - 1);
  localparam logic [TW-1:0] MID_T = TW'(LOW_CYC_P / 2);
  localparam logic [TW-1:0] WR_T = TW'(WR_WAIT_CYC - 1);

  typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP, HS_WAIT} seep_hst_t;
  typedef struct packed {
    seep_hst_t st;
    logic [TW-1:0] tick;
    logic [1:0] sub;
    logic [3:0] bitIdx;
    logic [1:0] byteNo;
    seep_op_t op;
    logic [2:0] cs;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [DW-1:0] sh;
    logic [DW-1:0] rx;
    logic [DW-1:0] len;
    logic reading;
    logic nack;
    logic sclOut;
    logic sdaDrv;
    logic rspValid;
    logic rspNack;
    logic rspLast;
  } seep_host_t;
  seep_host_t state_q;
  seep_host_t state_d;

  logic sdaS;
  logic tickDone;
  logic isWr;
  logic ackOut;
  logic curBit;
  logic reqProt;

  // Data pin into the clock domain
  seep_sync #(
    .W(1)
  ) u_sda (
    .clk(clk),
    .rst_b(rst_b),
    .din(link.sda),
    .dout(sdaS)
  );

  // Bit to put on the wire; last read byte is left unacknowledged
  assign tickDone = (state_q.tick == '0);
  assign isWr = (state_q.op == OP_WRITE) | (state_q.op == OP_PROT_SET);
  assign ackOut = state_q.reading ? (state_q.len == 8'h01) : 1'b1; // [RQ17] [RQ18]
  assign curBit = (state_q.bitIdx == ACK_BIT) ? ackOut : state_q.sh[DW-1];
  assign reqProt = (reqOp == OP_PROT_SET) | (reqOp == OP_PROT_QUERY);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: start, bits, stop, write-cycle wait
  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    state_d = state_q;
    state_d.rspValid = 1'b0;
    if (state_q.st == HS_IDLE) begin
      if (reqValid) begin
        state_d.op = reqOp;
        state_d.cs = reqCs;
        state_d.addr = reqAddr;
        state_d.data = reqData;
        state_d.len = (reqOp == OP_PROT_QUERY || reqLen == 8'h00) ? 8'h01 : reqLen;
        state_d.nack = 1'b0;
        state_d.reading = 1'b0;
        state_d.byteNo = 2'h0;
        // Type code, selects, direction; random read opens as a write
        state_d.sh = {reqProt ? CODE_PROT : CODE_ARRAY, reqCs,
                      (reqOp == OP_READ_CUR || reqOp == OP_PROT_QUERY)}; // [RQ3] [RQ11] [RQ19]
        state_d.st = HS_START;
        state_d.sub = 2'h0;
        state_d.tick = LOW_T;
        state_d.sclOut = 1'b0;
      end
    end else if (state_q.st == HS_WAIT) begin
      // Let the internal write cycle finish
      if (tickDone) begin
        state_d.st = HS_IDLE; // [RQ6]
      end else begin
        state_d.tick = state_q.tick - 1'b1;
      end
    end else if (!tickDone) begin
      state_d.tick = state_q.tick - 1'b1;
      // Except at start and stop, data changes only in the middle of the clock-low half
      if (state_q.sub == 2'h0 && state_q.tick == MID_T) begin
        state_d.sdaDrv = (state_q.st == HS_STOP) | ((state_q.st == HS_BIT) & ~curBit); // [RQ21]
      end
    end else if (state_q.sub == 2'h0) begin
      state_d.sub = 2'h1;
      state_d.sclOut = 1'b1;
      state_d.tick = HIGH_T;
    end else if (state_q.sub == 2'h1 && state_q.st != HS_BIT) begin
      // Data edge with the clock high: start pulls low, stop releases
      state_d.sub = 2'h2;
      state_d.tick = HIGH_T;
      state_d.sdaDrv = (state_q.st == HS_START);
    end else if (state_q.st == HS_START) begin
      state_d.st = HS_BIT;
      state_d.sub = 2'h0;
      state_d.bitIdx = 4'h0;
      state_d.tick = LOW_T;
      state_d.sclOut = 1'b0;
    end else if (state_q.st == HS_STOP) begin
      // Writes and no-acks answer after the stop; acked writes then wait out the write cycle
      state_d.st = (isWr && !state_q.nack) ? HS_WAIT : HS_IDLE; // [RQ6]
      state_d.tick = WR_T;
      state_d.rspValid = state_q.nack | isWr;
      state_d.rspNack = state_q.nack;
      state_d.rspLast = 1'b1;
    end else begin
      // End of a clock-high half: sample, then clock low again
      state_d.sub = 2'h0;
      state_d.sclOut = 1'b0;
      state_d.tick = LOW_T;
      if (state_q.bitIdx != ACK_BIT) begin
        state_d.bitIdx = state_q.bitIdx + 4'h1;
        state_d.sh = {state_q.sh[DW-2:0], 1'b1};
        if (state_q.reading) begin
          state_d.rx = {state_q.rx[DW-2:0], sdaS};
        end
      end else if (state_q.reading) begin
        state_d.bitIdx = 4'h0;
        state_d.rspValid = 1'b1;
        state_d.rspNack = 1'b0;
        state_d.rspLast = (state_q.len == 8'h01);
        state_d.len = state_q.len - 8'h01;
        if (state_q.len == 8'h01) begin
          state_d.st = HS_STOP; // [RQ18]
        end
      end else if (sdaS) begin
        // No acknowledge: a set flag on a query or flag set, or no such device
        state_d.nack = 1'b1; // [RQ11]
        state_d.st = HS_STOP;
      end else begin
        state_d.bitIdx = 4'h0;
        state_d.byteNo = state_q.byteNo + 2'h1;
        unique case (state_q.op)
          OP_READ_CUR, OP_PROT_QUERY: begin
            state_d.reading = 1'b1; // [RQ12]
            state_d.sh = 8'hFF;
          end
          OP_READ_RAND: begin
            if (state_q.byteNo == 2'h0) begin
              state_d.sh = state_q.addr; // [RQ16]
            end else begin
              // Repeated start, then a current-address read
              state_d.st = HS_START; // [RQ16]
              state_d.op = OP_READ_CUR;
              state_d.byteNo = 2'h0;
              state_d.sh = {CODE_ARRAY, state_q.cs, RW_READ};
            end
          end
          OP_WRITE, OP_PROT_SET: begin
            if (state_q.byteNo == 2'h0) begin
              state_d.sh = state_q.addr;
            end else if (state_q.byteNo == 2'h1) begin
              state_d.sh = state_q.data;
            end else begin
              state_d.st = HS_STOP;
            end
          end
        endcase
      end
    end
  end

  // State register; bus idles with both lines released
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
      state_q.sclOut <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign link.scl = state_q.sclOut;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOeB = ~state_q.sdaDrv;
  assign reqReady = (state_q.st == HS_IDLE);
  assign rspValid = state_q.rspValid;
  assign rspData = state_q.rx;
  assign rspNack = state_q.rspNack;
  assign rspLast = state_q.rspLast;
endmodule : seep_host

// ### testbench/seep_monitor.sv
// Concurrent checks on the two-wire link and the device's protect flag.
// Assumes the bench connects it by name to the link and device status.
module seep_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic hostSdaOeB,
  input wire logic devSdaOeB,
  // Device pin and status
  input wire logic writeProtect,
  input wire logic protectFlag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // Flag behaviour
  flag_one_way_a: assert property (!$fell(protectFlag))
    else $error("protect flag cleared");
  flag_pin_guard_a: assert property ($rose(protectFlag) |-> !$past(writeProtect, 4))
    else $error("protect flag set with pin high");
  flag_at_stop_a: assert property ($rose(protectFlag) |-> scl && sda)
    else $error("protect flag set outside a stop");
  ////////////////////////////////////////////////////////////////////////////////
  // Wire behaviour
  dev_drive_low_a: assert property (!devSdaOeB |-> !sda)
    else $error("device enable does not pull data low");
  host_drive_low_a: assert property (!hostSdaOeB |-> !sda)
    else $error("host enable does not pull data low");
  dev_edge_low_a: assert property ($changed(devSdaOeB) |-> !scl)
    else $error("device changed data while clock high");
  dev_release_a: assert property ($fell(devSdaOeB) |-> ##[1:300] devSdaOeB)
    else $error("device held data low too long");
  start_host_only_a: assert property ($fell(sda) && scl |-> devSdaOeB)
    else $error("device drove a start condition");
  // Main scenarios reached
  cover property ($rose(protectFlag));
  cover property ($fell(devSdaOeB));
  cover property ($fell(sda) && scl);
endmodule : seep_monitor

// ### testbench/seep_bench.sv
// Self-checking bench: host and device joined by the link interface.
// Assumes shortened host timing parameters; select straps driven by the bench.
module seep_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import seep_pkg::*;
  `define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
  logic clk, rst_b, reqValid, reqReady, rspValid, rspNack, rspLast, writeProtect, protFlag, nack;
  seep_op_t reqOp;
  logic [2:0] reqCs;
  logic [2:0] straps;
  logic [7:0] reqAddr, reqData, reqLen, rspData, addrCnt;
  logic [7:0] got[$];
  int failures = 0;
  int checksDone = 0;
  seep_link_if link ();
  seep_host #(.LOW_CYC_P(8), .HIGH_CYC_P(8), .WR_WAIT_CYC(16)) seep_host_i (.clk(clk),
    .rst_b(rst_b), .link(link), .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
    .reqCs(reqCs), .reqAddr(reqAddr), .reqData(reqData), .reqLen(reqLen),
    .rspValid(rspValid), .rspData(rspData), .rspNack(rspNack), .rspLast(rspLast));
  seep_device seep_device_i (.clk(clk), .rst_b(rst_b), .link(link),
    .chipSelectBit2(straps[2]), .chipSelectBit1(straps[1]), .chipSelectBit0(straps[0]),
    .writeProtect(writeProtect),
    .protectFlag(protFlag), .wordAddr(addrCnt));
  seep_monitor seep_monitor_i (.clk(clk), .rst_b(rst_b), .scl(link.scl), .sda(link.sda),
    .hostSdaOeB(link.hostSdaOeB), .devSdaOeB(link.devSdaOeB), .writeProtect(writeProtect),
    .protectFlag(protFlag));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Verdict and end of run
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stopTest
  // One request, answers gathered until the last one and the host idle again
  task automatic run(input seep_op_t op, input logic [2:0] cs, input logic [7:0] a, d, len);
    int n;
    n = 0;
    got.delete();
    reqOp = op;
    reqCs = cs;
    reqAddr = a;
    reqData = d;
    reqLen = len;
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    while (n < 20000) begin
      @(posedge clk);
      #1;
      n++;
      if (rspValid === 1'b1) begin
        got.push_back(rspData);
        nack = rspNack;
        if (rspLast === 1'b1) break;
      end
    end
    while (reqReady !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (4) @(posedge clk);
    #1;
    if (n >= 20000) begin
      failures++;
      stopTest();
    end
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'b0;
    reqValid = 1'b0;
    reqOp = OP_WRITE;
    reqCs = 3'h5;
    straps = 3'h5;
    reqAddr = 8'h00;
    reqData = 8'h00;
    reqLen = 8'h01;
    writeProtect = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    `CHK("flag", 1'b0, protFlag)
    // Writes, random, wrapping and current reads
    run(OP_WRITE, 3'h5, 8'h10, 8'h5A, 8'h01);
    run(OP_WRITE, 3'h5, 8'hFF, 8'h3C, 8'h01);
    run(OP_WRITE, 3'h5, 8'h00, 8'h81, 8'h01);
    run(OP_READ_RAND, 3'h5, 8'h10, 8'h00, 8'h01);
    `CHK("rd10", 8'h5A, got[0])
    `CHK("addr", 8'h11, addrCnt)
    run(OP_READ_RAND, 3'h5, 8'hFF, 8'h00, 8'h02);
    `CHK("rdFF", 8'h3C, got[0])
    `CHK("wrap", 8'h81, got[1])
    run(OP_READ_CUR, 3'h5, 8'h00, 8'h00, 8'h01);
    `CHK("cur", 8'h00, got[0])
    `CHK("addr2", 8'h02, addrCnt)
    run(OP_READ_CUR, 3'h0, 8'h00, 8'h00, 8'h01);
    `CHK("badCs", 1'b1, nack)
    // Another strap level: the matching select answers
    straps = 3'h2;
    run(OP_READ_CUR, 3'h2, 8'h00, 8'h00, 8'h01);
    `CHK("cs2", 1'b0, nack)
    straps = 3'h5;
    run(OP_PROT_QUERY, 3'h5, 8'h00, 8'h00, 8'h01);
    `CHK("qryClr", 1'b0, nack)
    $display("test reads done");
    // Pin high: array and flag both held
    writeProtect = 1'b1;
    run(OP_WRITE, 3'h5, 8'hA1, 8'h55, 8'h01);
    run(OP_PROT_SET, 3'h5, 8'h00, 8'h00, 8'h01);
    `CHK("setWp", 1'b0, nack)
    `CHK("flagWp", 1'b0, protFlag)
    run(OP_READ_RAND, 3'h5, 8'hA1, 8'h00, 8'h01);
    `CHK("wpA1", 8'h00, got[0])
    $display("test pin done");
    // Set flag, then lower half locked, upper half open
    writeProtect = 1'b0;
    run(OP_PROT_SET, 3'h5, 8'h12, 8'h34, 8'h01);
    `CHK("flagSet", 1'b1, protFlag)
    run(OP_PROT_QUERY, 3'h5, 8'h00, 8'h00, 8'h01);
    `CHK("qrySet", 1'b1, nack)
    run(OP_PROT_SET, 3'h5, 8'h00, 8'h00, 8'h01);
    `CHK("reSet", 1'b1, nack)
    run(OP_WRITE, 3'h5, 8'h7F, 8'h77, 8'h01);
    `CHK("loAck", 1'b0, nack)
    run(OP_WRITE, 3'h5, 8'h80, 8'h66, 8'h01);
    run(OP_READ_RAND, 3'h5, 8'h7F, 8'h00, 8'h02);
    `CHK("lo7F", 8'h00, got[0])
    `CHK("hi80", 8'h66, got[1])
    writeProtect = 1'b1;
    run(OP_WRITE, 3'h5, 8'h80, 8'h11, 8'h01);
    run(OP_READ_RAND, 3'h5, 8'h80, 8'h00, 8'h01);
    `CHK("wpHi", 8'h66, got[0])
    `CHK("flagKeep", 1'b1, protFlag)
    $display("test flag done");
    stopTest();
  end
endmodule : seep_bench
